// *** hdl/rsu_cfg.svh ***
// constants for the remote update image sequencer
`ifndef RSU_CFG_SVH
`define RSU_CFG_SVH
`define RSU_ADDR_W          24
`define RSU_WD_W            12
`define RSU_WD_LOW_ZEROS    17
`define RSU_SERIAL_BOOT     24'h000000
`define RSU_PARALLEL_BOOT   24'h010000
`define RSU_SECTOR_W        16
`define RSU_CAUSE_W         3
`define RSU_CAUSE_NONE      3'h0
`define RSU_CAUSE_FAULT     3'h1
`define RSU_CAUSE_CRC       3'h2
`define RSU_CAUSE_WDOG      3'h3
`define RSU_CAUSE_FABRIC    3'h4
`define RSU_CAUSE_PIN       3'h5
`define RSU_LOAD_CYCLES     8
`endif

// *** hdl/rsu_pkg.sv ***
// types for the remote update image sequencer
package rsu_pkg;
  typedef enum logic {
    RSU_SERIAL,
    RSU_PARALLEL
  } rsu_scheme_e;
  typedef enum logic [1:0] {
    RSU_IDLE,
    RSU_LOAD,
    RSU_USER
  } rsu_state_e;
  typedef struct packed {
    logic [23:0] addr;
    logic        wd_en;
    logic [11:0] wd_timer;
  } rsu_ctrl_s;
endpackage

// *** hdl/rsu_if.sv ***
// link between the sequencer and the fabric user logic
interface rsu_if;
  logic        upd_wr;
  rsu_pkg::rsu_ctrl_s upd_data;
  logic        reconfig_req;
  logic        wd_restart;
  logic        wr_denied;
  rsu_pkg::rsu_ctrl_s ctrl;
  logic [2:0]  cause;
  logic        is_factory;
  logic        user_mode;
  logic        cfg_start;
  modport device (input upd_wr, upd_data, reconfig_req, wd_restart,
                  output wr_denied, ctrl, cause, is_factory, user_mode, cfg_start);
  modport user   (output upd_wr, upd_data, reconfig_req, wd_restart,
                  input wr_denied, ctrl, cause, is_factory, user_mode, cfg_start);
endinterface

// *** hdl/rsu_sequencer.sv ***
// remote update image sequencer, device end
`include "rsu_cfg.svh"
module rsu_sequencer #(
  parameter int unsigned LOAD_CYCLES = `RSU_LOAD_CYCLES
) (
  input  wire logic                      sys_clk_in,
  input  wire logic                      rst_n_in,
  rsu_if.device                          bus,
  input  wire rsu_pkg::rsu_scheme_e      scheme_in,
  input  wire logic                      config_fault_line_n_in,
  input  wire logic                      crc_error_in,
  input  wire logic                      reconfig_request_n_in,
  input  wire logic                      factory_start_override_instr_in,
  input  wire logic [23:0]               override_addr_in,
  input  wire logic                      load_ok_in,
  output logic                           fetch_out,
  output logic [23:0]                    fetch_addr_out
);
  logic [1:0] fault_sync_ff, pin_sync_ff, ovr_sync_ff, crc_sync_ff;
  logic       pin_prev_ff, ovr_prev_ff;
  rsu_pkg::rsu_state_e state_ff;
  rsu_pkg::rsu_ctrl_s  upd_ff, ctrl_ff;
  logic [23:0] fact_addr_ff;
  logic        fact_ovr_ff;
  logic        factory_ff;
  logic [2:0]  cause_ff;
  logic [28:0] wd_cnt_ff;
  logic [15:0] load_cnt_ff;
  logic        wr_denied_ff;
  logic        user_mode_ff;
  logic [2:0]  nxt_cause;
  logic        start;
  logic        pin_fall;
  logic        wd_expire;
  logic [23:0] factory_addr;

  // factory address per scheme
  function automatic logic [23:0] fact_addr_f(input rsu_pkg::rsu_scheme_e s,
                                              input logic o, input logic [23:0] a);
    if (s == rsu_pkg::RSU_SERIAL)
      return `RSU_SERIAL_BOOT;
    return o ? a : `RSU_PARALLEL_BOOT;
  endfunction

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fault_sync_ff <= 2'h3;
      pin_sync_ff   <= 2'h3;
      ovr_sync_ff   <= 2'h0;
      crc_sync_ff   <= 2'h0;
      pin_prev_ff   <= 1'b1;
      ovr_prev_ff   <= 1'b0;
    end else begin
      fault_sync_ff <= {fault_sync_ff[0], config_fault_line_n_in};
      pin_sync_ff   <= {pin_sync_ff[0], reconfig_request_n_in};
      ovr_sync_ff   <= {ovr_sync_ff[0], factory_start_override_instr_in};
      crc_sync_ff   <= {crc_sync_ff[0], crc_error_in};
      pin_prev_ff   <= pin_sync_ff[1];
      ovr_prev_ff   <= ovr_sync_ff[1];
    end
  end

  assign pin_fall     = pin_prev_ff & ~pin_sync_ff[1];
  assign wd_expire    = (state_ff == rsu_pkg::RSU_USER) && !factory_ff && ctrl_ff.wd_en
                        && (wd_cnt_ff == 29'h0);
  assign factory_addr = fact_addr_f(scheme_in, fact_ovr_ff, fact_addr_ff);

  // cause priority: fault, crc, watchdog, fabric, pin
  always_comb begin
    nxt_cause = `RSU_CAUSE_NONE;
    if (!fault_sync_ff[1])
      nxt_cause = `RSU_CAUSE_FAULT;
    else if (crc_sync_ff[1])
      nxt_cause = `RSU_CAUSE_CRC;
    else if (wd_expire)
      nxt_cause = `RSU_CAUSE_WDOG;
    else if (bus.reconfig_req && state_ff == rsu_pkg::RSU_USER)
      nxt_cause = `RSU_CAUSE_FABRIC;
    else if (pin_fall)
      nxt_cause = `RSU_CAUSE_PIN;
  end
  assign start = (nxt_cause != `RSU_CAUSE_NONE) && (state_ff != rsu_pkg::RSU_IDLE);

  // factory address override latch
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fact_ovr_ff  <= 1'b0;
      fact_addr_ff <= `RSU_PARALLEL_BOOT;
    end else if (ovr_sync_ff[1] && !ovr_prev_ff && scheme_in == rsu_pkg::RSU_PARALLEL) begin
      fact_ovr_ff  <= 1'b1;
      fact_addr_ff <= override_addr_in;
    end
  end

  // update register, factory-only writes
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      upd_ff       <= '0;
      wr_denied_ff <= 1'b0;
    end else begin
      wr_denied_ff <= bus.upd_wr && !factory_ff;
      if (bus.upd_wr && factory_ff) begin
        upd_ff      <= bus.upd_data;
        upd_ff.addr <= {bus.upd_data.addr[23:2], 2'h0};
      end
    end
  end

  // sequencer state, control and status
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_ff    <= rsu_pkg::RSU_IDLE;
      ctrl_ff     <= '0;
      factory_ff  <= 1'b1;
      cause_ff    <= `RSU_CAUSE_NONE;
      load_cnt_ff <= 16'h0;
      fetch_out   <= 1'b0;
      fetch_addr_out <= 24'h0;
    end else begin
      fetch_out <= 1'b0;
      case (state_ff)
        rsu_pkg::RSU_IDLE: begin
          ctrl_ff.addr  <= factory_addr;
          ctrl_ff.wd_en <= 1'b0;
          factory_ff    <= 1'b1;
          fetch_out     <= 1'b1;
          fetch_addr_out <= factory_addr;
          load_cnt_ff   <= 16'(LOAD_CYCLES);
          state_ff      <= rsu_pkg::RSU_LOAD;
        end
        rsu_pkg::RSU_LOAD, rsu_pkg::RSU_USER: begin
          if (start) begin
            cause_ff <= nxt_cause;
            if (factory_ff && nxt_cause >= `RSU_CAUSE_FABRIC) begin
              ctrl_ff    <= upd_ff;
              factory_ff <= 1'b0;
              fetch_addr_out <= upd_ff.addr;
            end else begin
              ctrl_ff.addr  <= factory_addr;
              ctrl_ff.wd_en <= 1'b0;
              factory_ff    <= 1'b1;
              fetch_addr_out <= factory_addr;
            end
            fetch_out   <= 1'b1;
            load_cnt_ff <= 16'(LOAD_CYCLES);
            state_ff    <= rsu_pkg::RSU_LOAD;
          end else if (state_ff == rsu_pkg::RSU_LOAD) begin
            if (load_cnt_ff != 16'h0)
              load_cnt_ff <= load_cnt_ff - 16'h1;
            else if (load_ok_in)
              state_ff <= rsu_pkg::RSU_USER;
          end
        end
        default: state_ff <= rsu_pkg::RSU_IDLE;
      endcase
    end
  end

  // user mode flag, registered copy of the user state
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      user_mode_ff <= 1'b0;
    else if (start || state_ff == rsu_pkg::RSU_IDLE)
      user_mode_ff <= 1'b0;
    else if (state_ff == rsu_pkg::RSU_LOAD && load_cnt_ff == 16'h0 && load_ok_in)
      user_mode_ff <= 1'b1;
  end

  // user watchdog, 29-bit down counter
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      wd_cnt_ff <= 29'h1FFFFFFF;
    else if (factory_ff || !ctrl_ff.wd_en || state_ff != rsu_pkg::RSU_USER || bus.wd_restart)
      wd_cnt_ff <= {ctrl_ff.wd_timer, 17'h0};
    else if (wd_cnt_ff != 29'h0)
      wd_cnt_ff <= wd_cnt_ff - 29'h1;
  end

  assign bus.ctrl       = ctrl_ff;
  assign bus.cause      = cause_ff;
  assign bus.is_factory = factory_ff;
  assign bus.user_mode  = user_mode_ff;
  assign bus.cfg_start  = fetch_out;
  assign bus.wr_denied  = wr_denied_ff;
endmodule // rsu_sequencer

// *** hdl/rsu_user_logic.sv ***
// fabric user logic end of the remote update sequencer
`include "rsu_cfg.svh"
module rsu_user_logic (
  input  wire logic          sys_clk_in,
  input  wire logic          rst_n_in,
  rsu_if.user                bus,
  input  wire logic [23:0]   app_addr_in,
  input  wire logic          app_wd_en_in,
  input  wire logic [11:0]   app_wd_timer_in,
  input  wire logic          healthy_in,
  input  wire logic          new_image_stored_in,
  output logic [2:0]         last_cause_out,
  output logic               launched_out
);
  logic upd_wr_ff, req_ff, restart_ff, done_ff;

  // factory: read cause, write next image, then reconfigure
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      upd_wr_ff      <= 1'b0;
      req_ff         <= 1'b0;
      done_ff        <= 1'b0;
      last_cause_out <= `RSU_CAUSE_NONE;
      launched_out   <= 1'b0;
    end else begin
      upd_wr_ff <= 1'b0;
      req_ff    <= 1'b0;
      if (!bus.user_mode)
        done_ff <= 1'b0;
      else if (bus.is_factory && !done_ff) begin
        last_cause_out <= bus.cause;
        upd_wr_ff      <= 1'b1;
        done_ff        <= 1'b1;
      end else if (bus.is_factory && done_ff && !upd_wr_ff && !req_ff && !launched_out) begin
        req_ff       <= 1'b1;
        launched_out <= 1'b1;
      end else if (!bus.is_factory && new_image_stored_in) begin
        req_ff    <= 1'b1;
        // application also proposes the next image; the device refuses it
        upd_wr_ff <= 1'b1;
      end
      if (bus.cfg_start)
        launched_out <= 1'b0;
    end
  end

  // watchdog restart only while healthy in an application
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      restart_ff <= 1'b0;
    else
      restart_ff <= bus.user_mode && !bus.is_factory && healthy_in;
  end

  // never targets the factory image: only application settings written
  assign bus.upd_wr            = upd_wr_ff;
  assign bus.upd_data.addr     = app_addr_in;
  assign bus.upd_data.wd_en    = app_wd_en_in;
  assign bus.upd_data.wd_timer = app_wd_timer_in;
  assign bus.reconfig_req      = req_ff;
  assign bus.wd_restart        = restart_ff;
endmodule // rsu_user_logic

// *** sim/rsu_properties.sv ***
// interface checks for the remote update image sequencer
module rsu_properties (
  input wire logic               sys_clk_in,
  input wire logic               rst_n_in,
  input wire logic               upd_wr,
  input wire rsu_pkg::rsu_ctrl_s upd_data,
  input wire logic               reconfig_req,
  input wire logic               wd_restart,
  input wire logic               wr_denied,
  input wire rsu_pkg::rsu_ctrl_s ctrl,
  input wire logic [2:0]         cause,
  input wire logic               is_factory,
  input wire logic               user_mode,
  input wire logic               cfg_start
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  // one fetch pulse, then at least two cycles of loading
  sequence s_start;
    cfg_start;
  endsequence
  sequence s_load;
    (!cfg_start && !user_mode) [*2];
  endsequence
  a_load_gap_kept: assert property (s_start |=> s_load)
    else $error("fetch not followed by a load period");
  a_deny_app_write: assert property (upd_wr && !is_factory |=> wr_denied)
    else $error("application write not refused");
  a_allow_fac_write: assert property (upd_wr && is_factory |=> !wr_denied)
    else $error("factory write refused");
  a_factory_req_launch: assert property (
    reconfig_req && user_mode && is_factory |-> ##[1:2] cfg_start)
    else $error("factory request did not start a fetch");
  a_ctrl_on_start: assert property ($changed(ctrl) |-> ##[0:1] cfg_start)
    else $error("control changed without a reconfiguration");
  a_cause_on_start: assert property (
    $changed(cause) |-> (##[0:1] cfg_start) or $past(cfg_start))
    else $error("cause changed without a reconfiguration");
  a_wdog_off_fac: assert property (
    is_factory && user_mode |=> !($changed(cause) && cause == 3'h3))
    else $error("watchdog expired in factory image");
  a_error_to_fac: assert property (
    $changed(cause) && cause inside {3'h1, 3'h2, 3'h3} |-> ##[0:2] is_factory)
    else $error("error did not return to factory image");
endmodule // rsu_properties

// *** sim/testbench.sv ***
// self-checking bench joining sequencer and user logic
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin errors++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct { int ev; logic [2:0] cause; logic [23:0] addr; } rsu_tb_row_s;
  logic                 sys_clk  = 1'b0;
  logic                 rst_n    = 1'b0;
  rsu_pkg::rsu_scheme_e scheme   = rsu_pkg::RSU_SERIAL;
  logic                 fault_n  = 1'b1, crc = 1'b0, pin_n = 1'b1, ovr = 1'b0;
  logic                 load_ok  = 1'b1, wd_en = 1'b1, healthy = 1'b1, new_img = 1'b0;
  logic [23:0]          ovr_addr = 24'h000000, app_addr = 24'h020000;
  logic [11:0]          wd_timer = 12'h001;
  logic [23:0]          fetch_addr;
  logic [2:0]           last_cause;
  logic                 fetch, launched;
  int                   errors = 0, n_tests = 0, cyc = 0;
  rsu_tb_row_s          rows[4] = '{'{0, 3'h1, 24'h030000}, '{1, 3'h2, 24'h040000},
                                    '{2, 3'h5, 24'h050000}, '{3, 3'h4, 24'h060000}};
  rsu_if rsu_if_inst();
  rsu_sequencer #(.LOAD_CYCLES(2)) rsu_sequencer_inst (.sys_clk_in(sys_clk), .rst_n_in(rst_n),
    .bus(rsu_if_inst), .scheme_in(scheme), .config_fault_line_n_in(fault_n),
    .crc_error_in(crc), .reconfig_request_n_in(pin_n),
    .factory_start_override_instr_in(ovr), .override_addr_in(ovr_addr),
    .load_ok_in(load_ok), .fetch_out(fetch), .fetch_addr_out(fetch_addr));
  rsu_user_logic rsu_user_logic_inst (.sys_clk_in(sys_clk), .rst_n_in(rst_n), .bus(rsu_if_inst),
    .app_addr_in(app_addr), .app_wd_en_in(wd_en), .app_wd_timer_in(wd_timer),
    .healthy_in(healthy), .new_image_stored_in(new_img), .last_cause_out(last_cause),
    .launched_out(launched));
  rsu_properties rsu_properties_inst (.sys_clk_in(sys_clk), .rst_n_in(rst_n),
    .upd_wr(rsu_if_inst.upd_wr), .upd_data(rsu_if_inst.upd_data),
    .reconfig_req(rsu_if_inst.reconfig_req), .wd_restart(rsu_if_inst.wd_restart),
    .wr_denied(rsu_if_inst.wr_denied), .ctrl(rsu_if_inst.ctrl), .cause(rsu_if_inst.cause),
    .is_factory(rsu_if_inst.is_factory), .user_mode(rsu_if_inst.user_mode),
    .cfg_start(rsu_if_inst.cfg_start));
  always #2 sys_clk = ~sys_clk;
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // wait for the next fetch pulse and compare its address
  task automatic wait_fetch(input logic [23:0] exp);
    int i;
    i = 0;
    do begin
      @(posedge sys_clk);
      #1;
      i++;
    end while (fetch !== 1'b1 && i < 300);
    `CHK(fetch_addr, exp)
  endtask
  // wait until the image of the given kind runs in user mode
  task automatic wait_mode(input logic fac);
    int i;
    i = 0;
    do begin
      @(posedge sys_clk);
      #1;
      i++;
    end while ((rsu_if_inst.user_mode !== 1'b1 || rsu_if_inst.is_factory !== fac) && i < 300);
    `CHK(rsu_if_inst.is_factory, fac)
  endtask
  // drive one event for one cycle
  task automatic event_in(input int ev);
    @(posedge sys_clk);
    case (ev)
      0: fault_n <= 1'b0;
      1: crc <= 1'b1;
      2: pin_n <= 1'b0;
      3: new_img <= 1'b1;
      default: ovr <= 1'b1;
    endcase
    tick(1);
    fault_n <= 1'b1;
    crc <= 1'b0;
    pin_n <= 1'b1;
    new_img <= 1'b0;
    ovr <= 1'b0;
  endtask
  task automatic give_verdict;
    $display("TB: %0d checks, %0d errors", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      give_verdict();
    end
  end
  initial begin
    tick(4);
    `CHK(rsu_if_inst.is_factory, 1'b1)
    `CHK(rsu_if_inst.cfg_start, 1'b0)
    rst_n <= 1'b1;
    wait_fetch(24'h000000);
    wait_fetch(24'h020000);
    wait_mode(1'b0);
    $display("TB: power-up test done");
    foreach (rows[i]) begin
      app_addr <= rows[i].addr;
      event_in(rows[i].ev);
      wait_fetch(24'h000000);
      `CHK(rsu_if_inst.wr_denied, (rows[i].ev == 3))
      wait_mode(1'b1);
      `CHK(rsu_if_inst.cause, rows[i].cause)
      wait_fetch(rows[i].addr);
      wait_mode(1'b0);
      `CHK(last_cause, rows[i].cause)
      $display("TB: row %0d done", i);
    end
    wd_timer <= 12'h000;
    app_addr <= 24'h070000;
    event_in(2);
    wait_fetch(24'h000000);
    wait_fetch(24'h070000);
    wd_timer <= 12'h001;
    wait_fetch(24'h000000);
    `CHK(rsu_if_inst.cause, 3'h3)
    wait_mode(1'b1);
    wait_fetch(24'h070000);
    wait_mode(1'b0);
    $display("TB: watchdog test done");
    rst_n <= 1'b0;
    scheme <= rsu_pkg::RSU_PARALLEL;
    tick(4);
    rst_n <= 1'b1;
    wait_fetch(24'h010000);
    wait_fetch(24'h070000);
    wait_mode(1'b0);
    ovr_addr <= 24'h123400;
    event_in(4);
    event_in(0);
    wait_fetch(24'h123400);
    wait_mode(1'b1);
    `CHK(rsu_if_inst.cause, 3'h1)
    $display("TB: parallel test done");
    give_verdict();
  end
endmodule // testbench
